// *** clock_supervisor.sv ***
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Status flag set when system clock runs from configured external crystal source.
// - Start-up timer and status flag ignore the timekeeping oscillator.
// - Count 1024 external cycles before crystal modes drive the system clock; without two-speed the code selects external at once.
// - Non-crystal modes keep two-speed start-up disabled.
// - Count done before sleep sets flag and moves execution to external.
// - Sleep during start-up count aborts it and leaves flag clear.
// - Two-speed only with switchover bit, source select 00 and crystal mode; here the fail monitor bit also enables it.
// - Two-speed start-up entered after power-up timer and after wake-up.
// - Run internal while counting; on timeout sync edges, set flag, switch.
// - Switch delays: 2 cycles external or RC, 1024 crystal, 2 ms PLL.
// - Fail monitor enabled by configuration bit for every external mode.
// - Fail monitor inactive until start-up timer has expired.
// - Sample clock is low-frequency internal oscillator divided by 64.
// - Latch set on external falling edge, cleared on sample rising edge.
// - Failure when a full sample half-period passes without external low edge.
// - On failure switch to internal source and set fail flag.
// - Interrupt when fail flag and its enable are both set.
// - Fallback frequency is the programmed internal frequency select.
// - Fail condition cleared by reset, sleep or source select change.
// - Source change after failure restarts timer; on expiry return external.
// - Fail flag cannot be cleared while fail condition is active.
// - External clock and RC modes skip the start-up timer.
// - Enabling the fail monitor also enables two-speed start-up.
// - Source select 00 default, 01 timekeeping, 1x internal block.
// - Automatic switches leave source select unchanged.
module clock_supervisor (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Configuration and core events
  input wire logic [2:0] default_source_config_i,
  input wire logic switchover_enable_config_i,
  input wire logic fail_monitor_enable_config_i,
  input wire logic power_up_done_i,
  input wire logic sleep_i,
  input wire logic wake_i,
  // Oscillator pins and readiness
  input wire logic ext_osc_i,
  input wire logic low_freq_internal_osc_i,
  input wire logic timekeeping_osc_ready_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  output logic [7:0] rdata_o,
  // Clock steering
  output logic use_external_o,
  output logic [3:0] internal_freq_select_o,
  output logic [1:0] source_select_o,
  output logic clock_hold_low_o,
  output logic pll_ready_o,
  output logic oscillator_fail_irq_o
);

  typedef enum logic [2:0] {ST_IDLE, ST_COUNT, ST_WAIT_INT, ST_HOLD, ST_RUN, ST_SLEEP} start_e;

  start_e state_r;
  logic [1:0] ext_sync_r;
  logic ext_prev_r;
  logic [1:0] lf_sync_r;
  logic lf_prev_r;
  logic [10:0] count_r;
  logic [4:0] div_r;
  logic sample_r;
  logic [5:0] half_r;
  logic seen_low_r;
  logic fail_cond_r;
  logic fail_flag_r;
  logic fail_ie_r;
  logic startup_timeout_status_r;
  logic [1:0] source_select_r;
  logic [3:0] internal_freq_select_r;
  logic pll_enable_r;
  logic [16:0] pll_count_r;
  logic pll_ready_r;
  logic [7:0] rdata_r;
  logic crystal_mode;
  logic ext_fall;
  logic lf_rise;
  logic sample_rise;
  logic wr_control;
  logic src_change;
  logic need_count;
  logic [10:0] count_target;
  logic monitor_on;
  logic fail_detect;
  logic [1:0] tk_sync_r;
  logic [1:0] pwr_sync_r;
  logic half_done;
  logic tk_ready;
  logic flag_clear;
  logic wr_irq_enable;
  logic use_external_r;
  logic clock_hold_low_r;
  logic fail_irq_r;

  // Edge detection after two-stage synchronisers
  assign ext_fall = ext_prev_r & ~ext_sync_r[1];
  assign lf_rise = ~lf_prev_r & lf_sync_r[1];
  assign crystal_mode = (default_source_config_i == clock_supervisor_pkg::MODE_LOW_POWER) |
                        (default_source_config_i == clock_supervisor_pkg::MODE_CRYSTAL) |
                        (default_source_config_i == clock_supervisor_pkg::MODE_HIGH_SPEED);
  // Crystal needs long count, external clock and RC only two cycles
  assign need_count = crystal_mode;
  assign count_target = crystal_mode ?
    11'(clock_supervisor_pkg::STARTUP_CYCLES) :
    11'(clock_supervisor_pkg::FAST_SWITCH_CYCLES);
  assign wr_control = write_i & (addr_i == clock_supervisor_pkg::ADDR_CONTROL);
  assign src_change = wr_control &
    (wdata_i[clock_supervisor_pkg::CTRL_SRC_LSB +: 2] != source_select_r);
  assign sample_rise = lf_rise & (div_r == 5'h1F) & ~sample_r;
  // Half-period watch: the 32nd internal edge after a sample rise
  assign half_done = lf_rise & (half_r == 6'(clock_supervisor_pkg::SAMPLE_HALF - 1));
  assign tk_ready = tk_sync_r[1];
  assign flag_clear = write_i & (addr_i == clock_supervisor_pkg::ADDR_FLAGS) & ~wdata_i[0];
  assign wr_irq_enable = write_i & (addr_i == clock_supervisor_pkg::ADDR_IRQ_ENABLE);

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_sync_r <= 2'h0;
      ext_prev_r <= 1'b0;
    end else begin
      ext_sync_r <= {ext_sync_r[0], ext_osc_i};
      ext_prev_r <= ext_sync_r[1];
    end
  end

  // Low-frequency internal oscillator synchroniser
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lf_sync_r <= 2'h0;
      lf_prev_r <= 1'b0;
    end else begin
      lf_sync_r <= {lf_sync_r[0], low_freq_internal_osc_i};
      lf_prev_r <= lf_sync_r[1];
    end
  end

  // Timekeeping ready arrives from its own oscillator domain
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tk_sync_r <= 2'h0;
    end else begin
      tk_sync_r <= {tk_sync_r[0], timekeeping_osc_ready_i};
    end
  end

  // Power-up timer runs from the low-frequency oscillator
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwr_sync_r <= 2'h0;
    end else begin
      pwr_sync_r <= {pwr_sync_r[0], power_up_done_i};
    end
  end

  // Sample clock: toggles every 32 internal cycles, period of 64
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_r <= 5'h00;
      sample_r <= 1'b0;
    end else if (lf_rise) begin
      div_r <= div_r + 5'h01;
      if (div_r == 5'h1F) begin
        sample_r <= ~sample_r;
      end
    end
  end

  // Start-up sequencer
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= ST_IDLE;
      count_r <= 11'h000;
      startup_timeout_status_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          startup_timeout_status_r <= 1'b0;
          count_r <= 11'h000;
          if (pwr_sync_r[1]) begin
            state_r <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (sleep_i) begin
            count_r <= 11'h000;
            startup_timeout_status_r <= 1'b0;
            state_r <= ST_SLEEP;
          end else if (ext_fall) begin
            if (count_r == count_target - 11'h001) begin
              state_r <= ST_WAIT_INT;
            end else begin
              count_r <= count_r + 11'h001;
            end
          end
        end
        ST_WAIT_INT: begin
          if (sleep_i) begin
            state_r <= ST_SLEEP;
          end else if (~lf_prev_r | ~need_count) begin
            startup_timeout_status_r <= need_count;
            state_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (sleep_i) begin
            startup_timeout_status_r <= 1'b0;
            state_r <= ST_SLEEP;
          end else if (ext_fall | ~need_count) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (sleep_i) begin
            startup_timeout_status_r <= 1'b0;
            state_r <= ST_SLEEP;
          end else if (src_change) begin
            count_r <= 11'h000;
            startup_timeout_status_r <= 1'b0;
            state_r <= ST_COUNT;
          end
        end
        ST_SLEEP: begin
          count_r <= 11'h000;
          if (wake_i) begin
            state_r <= ST_COUNT;
          end
        end
      endcase
    end
  end

  // Fail detector: latch and half-period watch
  assign monitor_on = fail_monitor_enable_config_i & (state_r == ST_RUN);
  assign fail_detect = monitor_on & half_done & ~seen_low_r & ~ext_fall;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      seen_low_r <= 1'b0;
    end else if (ext_fall) begin
      seen_low_r <= 1'b1;
    end else if (sample_rise) begin
      seen_low_r <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      half_r <= 6'h00;
    end else if (sample_rise) begin
      half_r <= 6'h00;
    end else if (lf_rise & (half_r != 6'(clock_supervisor_pkg::SAMPLE_HALF))) begin
      half_r <= half_r + 6'h01;
    end
  end

  // Fail condition clears on sleep, source change or timer expiry
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fail_cond_r <= 1'b0;
    end else if (fail_detect) begin
      fail_cond_r <= 1'b1;
    end else if (sleep_i | src_change | (state_r == ST_HOLD)) begin
      fail_cond_r <= 1'b0;
    end
  end

  // Sticky flag: set wins, clear blocked while condition active
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fail_flag_r <= 1'b0;
    end else if (fail_detect) begin
      fail_flag_r <= 1'b1;
    end else if (flag_clear & ~fail_cond_r) begin
      // Software clear loses to a new failure
      fail_flag_r <= 1'b0;
    end
  end

  // Software registers; automatic switches never touch source select
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      source_select_r <= clock_supervisor_pkg::SRC_RESET;
      internal_freq_select_r <= clock_supervisor_pkg::FREQ_RESET;
      pll_enable_r <= 1'b0;
      fail_ie_r <= 1'b0;
    end else if (wr_control) begin
      source_select_r <= wdata_i[clock_supervisor_pkg::CTRL_SRC_LSB +: 2];
      internal_freq_select_r <= wdata_i[clock_supervisor_pkg::CTRL_FREQ_LSB +: 4];
      pll_enable_r <= wdata_i[clock_supervisor_pkg::CTRL_PLL_BIT];
    end else if (wr_irq_enable) begin
      fail_ie_r <= wdata_i[0];
    end
  end

  // PLL lock delay
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pll_count_r <= 17'h00000;
      pll_ready_r <= 1'b0;
    end else if (!pll_enable_r) begin
      pll_count_r <= 17'h00000;
      pll_ready_r <= 1'b0;
    end else if (pll_count_r == 17'(clock_supervisor_pkg::PLL_LOCK_CYCLES - 1)) begin
      pll_ready_r <= 1'b1;
    end else begin
      pll_count_r <= pll_count_r + 17'h00001;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_r <= 8'h00;
    end else if (read_i) begin
      unique case (addr_i)
        clock_supervisor_pkg::ADDR_CONTROL:
          rdata_r <= {pll_enable_r, internal_freq_select_r, 1'b0, source_select_r};
        clock_supervisor_pkg::ADDR_STATUS:
          rdata_r <= {5'h00, fail_cond_r, tk_ready,
                      startup_timeout_status_r};
        clock_supervisor_pkg::ADDR_FLAGS:
          rdata_r <= {7'h00, fail_flag_r};
        clock_supervisor_pkg::ADDR_IRQ_ENABLE:
          rdata_r <= {7'h00, fail_ie_r};
        default:
          rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // Two-speed enable and source steering
  logic two_speed;
  assign two_speed = (switchover_enable_config_i | fail_monitor_enable_config_i) &
                     (source_select_r == clock_supervisor_pkg::SRC_DEFAULT) &
                     crystal_mode;

  // Default source runs external after start-up under two-speed, at once otherwise; never during failure
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      use_external_r <= 1'b0;
      clock_hold_low_r <= 1'b0;
      fail_irq_r <= 1'b0;
    end else begin
      use_external_r <= (source_select_r == clock_supervisor_pkg::SRC_DEFAULT) &
                        (default_source_config_i != clock_supervisor_pkg::MODE_INTERNAL) &
                        ~fail_cond_r &
                        ((state_r == ST_RUN) | ~two_speed);
      clock_hold_low_r <= (state_r == ST_HOLD) & need_count;
      fail_irq_r <= fail_flag_r & fail_ie_r;
    end
  end

  // Outputs
  assign use_external_o = use_external_r;
  assign internal_freq_select_o = internal_freq_select_r;
  assign source_select_o = source_select_r;
  assign clock_hold_low_o = clock_hold_low_r;
  assign pll_ready_o = pll_ready_r;
  assign oscillator_fail_irq_o = fail_irq_r;
  assign rdata_o = rdata_r;

endmodule : clock_supervisor
`default_nettype wire

// *** clock_supervisor_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module clock_supervisor_asserts (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Core events and register port
  input wire logic sleep_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  // Outputs
  input wire logic [7:0] rdata_o,
  input wire logic use_external_o,
  input wire logic [3:0] internal_freq_select_o,
  input wire logic [1:0] source_select_o,
  input wire logic clock_hold_low_o,
  input wire logic pll_ready_o,
  input wire logic oscillator_fail_irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  wire ctrl_wr = write_i && addr_i == clock_supervisor_pkg::ADDR_CONTROL;
  property p_src_write; ctrl_wr |=> source_select_o == $past(wdata_i[1:0]); endproperty
  a_src_write: assert property (p_src_write) else $error("source select not written");
  property p_freq_write; ctrl_wr |=> internal_freq_select_o == $past(wdata_i[6:3]); endproperty
  a_freq_write: assert property (p_freq_write) else $error("freq select not written");
  property p_src_kept; !ctrl_wr |=> $stable({source_select_o, internal_freq_select_o}); endproperty
  a_src_kept: assert property (p_src_kept) else $error("control fields moved");
  property p_sleep_abort; sleep_i && !use_external_o |=> !use_external_o [*2]; endproperty
  a_sleep_abort: assert property (p_sleep_abort) else $error("switch after sleep");
  property p_hold_int; clock_hold_low_o |-> !use_external_o; endproperty
  a_hold_int: assert property (p_hold_int) else $error("external during hold");
  property p_hold_end; $rose(clock_hold_low_o) |-> ##[1:64] !clock_hold_low_o; endproperty
  a_hold_end: assert property (p_hold_end) else $error("hold too long");
  property p_hold_ext; $fell(clock_hold_low_o) && !$past(sleep_i) |-> use_external_o; endproperty
  a_hold_ext: assert property (p_hold_ext) else $error("no switch after hold");
  property p_irq_fail; $rose(oscillator_fail_irq_o) && !$past(write_i) |-> ##[0:2] !use_external_o;
  endproperty
  a_irq_fail: assert property (p_irq_fail) else $error("fail without fallback");
  property p_pll_wait; ctrl_wr && wdata_i[7] && !pll_ready_o |=> !pll_ready_o [*8]; endproperty
  a_pll_wait: assert property (p_pll_wait) else $error("pll ready too soon");
  property p_status_shape; read_i && addr_i == clock_supervisor_pkg::ADDR_STATUS |=> rdata_o[7:3] == 5'h00;
  endproperty
  a_status_shape: assert property (p_status_shape) else $error("status high bits set");
endmodule : clock_supervisor_asserts
bind clock_supervisor clock_supervisor_asserts chk (.clock_i, .resetn_i, .sleep_i, .addr_i,
  .wdata_i, .write_i, .read_i, .rdata_o, .use_external_o, .internal_freq_select_o,
  .source_select_o, .clock_hold_low_o, .pll_ready_o, .oscillator_fail_irq_o);
`default_nettype wire

// *** clock_supervisor_pkg.sv ***
package clock_supervisor_pkg;

  // Oscillator modes held in the default source configuration
  localparam logic [2:0] MODE_LOW_POWER = 3'h0;
  localparam logic [2:0] MODE_CRYSTAL = 3'h1;
  localparam logic [2:0] MODE_HIGH_SPEED = 3'h2;
  localparam logic [2:0] MODE_RC = 3'h3;
  localparam logic [2:0] MODE_INTERNAL = 3'h4;
  localparam logic [2:0] MODE_EXT_CLOCK = 3'h5;

  // Source select encodings
  localparam logic [1:0] SRC_DEFAULT = 2'h0;
  localparam logic [1:0] SRC_TIMEKEEPING = 2'h1;

  // Counts
  localparam int STARTUP_CYCLES = 1024;
  localparam int FAST_SWITCH_CYCLES = 2;
  localparam int SAMPLE_DIVIDE = 64;
  localparam int SAMPLE_HALF = SAMPLE_DIVIDE / 2;
  localparam int CLOCK_MHZ = 50;
  localparam int PLL_LOCK_US = 2000;
  localparam int PLL_LOCK_CYCLES = PLL_LOCK_US * CLOCK_MHZ;

  // Register map of the plain port
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_FLAGS = 4'h2;
  localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h3;

  // Control register fields
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_FREQ_LSB = 3;
  localparam int CTRL_PLL_BIT = 7;

  // Values after reset
  localparam logic [1:0] SRC_RESET = 2'h0;
  localparam logic [3:0] FREQ_RESET = 4'h7;

endpackage : clock_supervisor_pkg

// *** ext_osc_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module ext_osc_model #(
  parameter int HALF = 40
) (
  // Control
  input wire logic run_i,
  // Oscillator pin
  output logic osc_o
);
  // A stalled crystal freezes at its last level
  initial begin
    osc_o = 1'b0;
    forever begin
      #HALF;
      if (run_i) osc_o = ~osc_o;
    end
  end
endmodule : ext_osc_model
`default_nettype wire

// *** test_clock_supervisor.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module test_clock_supervisor;
  localparam logic [3:0] A_CTL = clock_supervisor_pkg::ADDR_CONTROL;
  localparam logic [3:0] A_STS = clock_supervisor_pkg::ADDR_STATUS;
  localparam logic [3:0] A_FLG = clock_supervisor_pkg::ADDR_FLAGS;
  logic [2:0] default_source_config_i = clock_supervisor_pkg::MODE_CRYSTAL;
  logic clock_i = 0, resetn_i = 0, switchover_enable_config_i = 0, fail_monitor_enable_config_i = 1;
  logic power_up_done_i = 0, sleep_i = 0, wake_i = 0, low_freq_internal_osc_i = 0;
  logic timekeeping_osc_ready_i = 0, write_i = 0, read_i = 0, rd_q = 0, ext_run = 1;
  logic [3:0] addr_i = 0, f, internal_freq_select_o;
  logic [7:0] wdata_i = 0, e_v, st, rdata_o, exp_q[$];
  logic use_external_o, clock_hold_low_o, pll_ready_o, oscillator_fail_irq_o;
  logic [1:0] source_select_o;
  logic [31:0] seed = 32'hBE7D;
  wire ext_osc_i;
  int failures = 0, n_compared = 0, cycles = 0;
  initial forever #10 clock_i = ~clock_i;
  initial forever #80 low_freq_internal_osc_i = ~low_freq_internal_osc_i;
  ext_osc_model #(.HALF(40)) osc (.run_i(ext_run), .osc_o(ext_osc_i));
  clock_supervisor dut (.clock_i, .resetn_i, .default_source_config_i, .switchover_enable_config_i,
    .fail_monitor_enable_config_i, .power_up_done_i, .sleep_i, .wake_i, .ext_osc_i,
    .low_freq_internal_osc_i, .timekeeping_osc_ready_i, .addr_i, .wdata_i, .write_i, .read_i,
    .rdata_o, .use_external_o, .internal_freq_select_o, .source_select_o, .clock_hold_low_o,
    .pll_ready_o, .oscillator_fail_irq_o);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i) {write_i, addr_i, wdata_i} <= {1'b1, a, d};
    @(posedge clock_i) write_i <= 0;
    @(negedge clock_i);
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock_i) {read_i, addr_i} <= {1'b1, a};
    exp_q.push_back(e);
    @(posedge clock_i) read_i <= 0;
  endtask : rd_reg
  task automatic wait_ext(input logic v);
    for (int i = 0; i < 8000 && use_external_o !== v; i++) @(negedge clock_i);
    `CHK(use_external_o, v)
  endtask : wait_ext
  task automatic nap(input int n);
    @(posedge clock_i) sleep_i <= 1;
    @(posedge clock_i) sleep_i <= 0;
    repeat (4) @(posedge clock_i);
    wake_i <= 1;
    @(posedge clock_i) wake_i <= 0;
    repeat (n) @(posedge clock_i);
  endtask : nap
  // Read results are compared one cycle after each request
  always @(posedge clock_i) begin
    cycles++;
    rd_q <= read_i;
    if (rd_q) begin
      e_v = exp_q.pop_front();
      `CHK(rdata_o, e_v)
    end
    if (cycles == 40000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    st = xs();
    f = st[6:3];
    repeat (6) @(posedge clock_i);
    resetn_i <= 1;
    timekeeping_osc_ready_i <= st[0];
    @(negedge clock_i);
    `CHK({use_external_o, source_select_o, internal_freq_select_o, oscillator_fail_irq_o}, 8'h0E)
    rd_reg(A_CTL, 8'h38);
    rd_reg(A_STS, {6'h00, st[0], 1'b0});
    rd_reg(4'h9, 8'h00);
    wr_reg(clock_supervisor_pkg::ADDR_IRQ_ENABLE, 8'h01);
    $display("reset test done");
    @(posedge clock_i) power_up_done_i <= 1;
    repeat (3000) @(negedge clock_i);
    `CHK(use_external_o, 1'b0)
    wait_ext(1'b1);
    rd_reg(A_STS, {6'h00, st[0], 1'b1});
    wr_reg(A_CTL, {1'b1, f, 3'h0});
    `CHK({internal_freq_select_o, pll_ready_o}, {f, 1'b0})
    $display("start-up test done");
    @(posedge clock_i) ext_run <= 0;
    wait_ext(1'b0);
    `CHK({oscillator_fail_irq_o, source_select_o, internal_freq_select_o}, {3'b100, f})
    wr_reg(A_FLG, 8'h00);
    rd_reg(A_FLG, 8'h01);
    $display("fail test done");
    @(posedge clock_i) ext_run <= 1;
    wr_reg(A_CTL, {1'b0, f, 3'h2});
    wr_reg(A_CTL, {1'b0, f, 3'h0});
    `CHK(use_external_o, 1'b0)
    wait_ext(1'b1);
    rd_reg(A_STS, {6'h00, st[0], 1'b1});
    wr_reg(A_FLG, 8'h00);
    rd_reg(A_FLG, 8'h00);
    `CHK(oscillator_fail_irq_o, 1'b0)
    $display("recovery test done");
    nap(2000);
    nap(0);
    rd_reg(A_STS, {6'h00, st[0], 1'b0});
    wait_ext(1'b1);
    $display("sleep test done");
    @(posedge clock_i) resetn_i <= 0;
    default_source_config_i <= clock_supervisor_pkg::MODE_EXT_CLOCK;
    repeat (6) @(posedge clock_i);
    resetn_i <= 1;
    repeat (40) @(negedge clock_i);
    `CHK(use_external_o, 1'b1)
    $display("external clock test done");
    @(posedge clock_i) timekeeping_osc_ready_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    rd_reg(A_STS, 8'h02);
    wr_reg(A_CTL, {1'b0, f, 3'h1});
    repeat (2) @(negedge clock_i);
    `CHK({use_external_o, source_select_o}, 3'b001)
    $display("timekeeping test done");
    complete_run();
  end
endmodule : test_clock_supervisor
`default_nettype wire
